// ---- core/sfb_pkg.sv ----
`default_nettype none
package sfb_pkg;

  // Register map, byte offsets in the low address byte
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STS = 8'h08;
  localparam logic [7:0] OFS_PTR = 8'h0C;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_BIT_W = 3;
  localparam int CMD_BUSY_BIT = 8;

  // Status register flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam int MSB_BIT = 7;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;

  // Reset values and pointer step
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] STS_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // AHB-Lite codes
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    OP_SHL = 4'h0, OP_SHR = 4'h1, OP_ROTL = 4'h2, OP_ROTR = 4'h3,
    OP_SAR = 4'h4, OP_S_SET = 4'h5, OP_S_CLR = 4'h6, OP_V_SET = 4'h7,
    OP_V_CLR = 4'h8, OP_H_SET = 4'h9, OP_H_CLR = 4'hA, OP_BIT_TO_T = 4'hB,
    OP_T_TO_BIT = 4'hC, OP_LOAD_POST = 4'hD, OP_LOAD_PRE = 4'hE,
    OP_LOAD = 4'hF
  } sfb_op_t;

  typedef enum logic [0:0] {
    LOAD_IDLE = 1'b0,
    LOAD_READ = 1'b1
  } sfb_load_state_t;

  // One-hot mask of a status flag
  function automatic logic [7:0] flag_mask(input int pos);
    return 8'h01 << pos;
  endfunction : flag_mask

endpackage : sfb_pkg
`default_nettype wire

// ---- core/sfb_ifs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation request to the shift and flag unit
interface sfb_alu_if;
  import sfb_pkg::*;
  sfb_op_t op;
  logic [2:0] bit_idx;
  logic [7:0] wreg;
  logic [7:0] sts;
  logic [7:0] wreg_nxt;
  logic [7:0] sts_nxt;
  logic is_load;
  modport core (output op, bit_idx, wreg, sts,
                input wreg_nxt, sts_nxt, is_load);
  modport unit (input op, bit_idx, wreg, sts,
                output wreg_nxt, sts_nxt, is_load);
endinterface : sfb_alu_if

// Indirect load request and memory side
interface sfb_load_if;
  import sfb_pkg::*;
  logic start;
  sfb_op_t op;
  logic [15:0] ptr;
  logic busy;
  logic done;
  logic ptr_we;
  logic [15:0] ptr_new;
  logic mem_rd;
  logic [15:0] mem_addr;
  modport core (output start, op, ptr,
                input busy, done, ptr_we, ptr_new, mem_rd, mem_addr);
  modport seq (input start, op, ptr,
               output busy, done, ptr_we, ptr_new, mem_rd, mem_addr);
endinterface : sfb_load_if
`default_nettype wire

// ---- core/sfb_shift_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfb_shift_unit (
  sfb_alu_if.unit alu
);
  import sfb_pkg::*;

  // Z, C, N and V after a shift or rotate
  function automatic logic [7:0] shift_flags(input logic [7:0] s,
                                             input logic [7:0] r,
                                             input logic c);
    logic [7:0] f;
    f = s;
    f[FLG_C] = c;
    f[FLG_Z] = (r == 8'h00);
    f[FLG_N] = r[MSB_BIT];
    f[FLG_V] = r[MSB_BIT] ^ c;
    return f;
  endfunction : shift_flags

  logic [7:0] w;
  logic [7:0] s;
  logic [7:0] res_shl, res_shr, res_rotl, res_rotr, res_sar, res_tbit;
  logic [7:0] bit_sel;

  // Shift, rotate and bit-load results
  assign w = alu.wreg;
  assign s = alu.sts;
  assign res_shl = {w[MSB_BIT-1:0], 1'b0}; // RULE_01
  assign res_shr = {1'b0, w[MSB_BIT:1]}; // RULE_02
  assign res_rotl = {w[MSB_BIT-1:0], s[FLG_C]}; // RULE_03
  assign res_rotr = {s[FLG_C], w[MSB_BIT:1]}; // RULE_04
  assign res_sar = {w[MSB_BIT], w[MSB_BIT:1]}; // RULE_05
  assign bit_sel = 8'h01 << alu.bit_idx;
  assign res_tbit = s[FLG_T] ? (w | bit_sel) : (w & ~bit_sel); // RULE_10

  // Working register result per operation
  assign alu.wreg_nxt =
    (alu.op == OP_SHL) ? res_shl :
    (alu.op == OP_SHR) ? res_shr :
    (alu.op == OP_ROTL) ? res_rotl :
    (alu.op == OP_ROTR) ? res_rotr :
    (alu.op == OP_SAR) ? res_sar :
    (alu.op == OP_T_TO_BIT) ? res_tbit : w;

  // Status result; a process so it follows every operand
  always_comb begin
    alu.sts_nxt = s;
    case (alu.op)
      OP_SHL: alu.sts_nxt = shift_flags(s, res_shl, w[MSB_BIT]); // RULE_13
      OP_SHR: alu.sts_nxt = shift_flags(s, res_shr, w[0]); // RULE_02
      OP_ROTL: alu.sts_nxt = shift_flags(s, res_rotl, w[MSB_BIT]); // RULE_03
      OP_ROTR: alu.sts_nxt = shift_flags(s, res_rotr, w[0]); // RULE_04
      OP_SAR: alu.sts_nxt = shift_flags(s, res_sar, w[0]); // RULE_05
      OP_S_SET: alu.sts_nxt[FLG_S] = 1'b1; // RULE_06
      OP_S_CLR: alu.sts_nxt[FLG_S] = 1'b0; // RULE_06
      OP_V_SET: alu.sts_nxt[FLG_V] = 1'b1; // RULE_07
      OP_V_CLR: alu.sts_nxt[FLG_V] = 1'b0; // RULE_07
      OP_H_SET: alu.sts_nxt[FLG_H] = 1'b1; // RULE_08
      OP_H_CLR: alu.sts_nxt[FLG_H] = 1'b0; // RULE_08
      OP_BIT_TO_T: alu.sts_nxt[FLG_T] = w[alu.bit_idx]; // RULE_09
      default: alu.sts_nxt = s;
    endcase
  end

  assign alu.is_load = (alu.op == OP_LOAD_POST) ||
                       (alu.op == OP_LOAD_PRE) || (alu.op == OP_LOAD);

endmodule : sfb_shift_unit
`default_nettype wire

// ---- core/sfb_load_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfb_load_seq (
  input wire logic hclk,
  input wire logic hresetn,
  sfb_load_if.seq load
);
  import sfb_pkg::*;

  sfb_load_state_t state_r;
  sfb_op_t op_r;
  logic mem_rd_r;
  logic [15:0] mem_addr_r;
  logic pre_go;
  logic [15:0] ptr_dec;

  // Pointer arithmetic and status
  assign pre_go = load.start && (load.op == OP_LOAD_PRE);
  assign ptr_dec = load.ptr - PTR_STEP;
  assign load.busy = (state_r == LOAD_READ);
  assign load.done = load.busy;
  assign load.ptr_we = pre_go ||
                       (load.done && op_r == OP_LOAD_POST); // RULE_11
  assign load.ptr_new = load.busy ? load.ptr + PTR_STEP : ptr_dec; // RULE_12
  assign load.mem_rd = mem_rd_r;
  assign load.mem_addr = mem_addr_r;

  // Issue cycle then capture cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= LOAD_IDLE;
      op_r <= OP_LOAD;
      mem_rd_r <= 1'b0;
      mem_addr_r <= PTR_RST;
    end else begin
      case (state_r)
        LOAD_IDLE: begin
          if (load.start) begin
            state_r <= LOAD_READ;
            op_r <= load.op;
            mem_rd_r <= 1'b1;
            mem_addr_r <= pre_go ? ptr_dec : load.ptr; // RULE_12
          end
        end
        LOAD_READ: begin
          state_r <= LOAD_IDLE;
          mem_rd_r <= 1'b0;
        end
        default: begin
          state_r <= LOAD_IDLE;
          mem_rd_r <= 1'b0;
        end
      endcase
    end
  end

endmodule : sfb_load_seq
`default_nettype wire

// ---- core/sfb_top.sv ----
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Left shift, zero into bit 0, one clock
// RULE_02: Right shift, zero into bit 7, flags
// RULE_03: Rotate left through carry in one clock
// RULE_04: Rotate right through carry in one clock
// RULE_05: Arithmetic right shift keeps bit 7, flags
// RULE_06: Set or clear signed flag only
// RULE_07: Set or clear overflow flag only
// RULE_08: Set or clear half-carry flag only
// RULE_09: Copy register bit into transfer flag
// RULE_10: Copy transfer flag into register bit
// RULE_11: Load at pointer, then increment, two clocks
// RULE_12: Decrement pointer, then load, two clocks
// RULE_13: Left shift sets carry from bit 7, zero
module sfb_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [sfb_pkg::PTR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [sfb_pkg::DATA_W-1:0] mem_rdata
);
  import sfb_pkg::*;

  sfb_alu_if alu_bus();
  sfb_load_if load_bus();

  // Bus side state
  logic take;
  logic wr_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic hresp_r;

  // Datapath registers
  logic [7:0] wreg_r;
  logic [7:0] sts_r;
  logic [15:0] ptr_r;
  logic [6:0] cmd_r;
  logic [7:0] wreg_nxt;
  logic [7:0] sts_nxt;
  logic [15:0] ptr_nxt;

  // Decoded strobes
  logic busy;
  logic wr_cmd;
  logic cmd_go;
  logic exec;
  logic sw_ok;
  logic wr_wreg;
  logic wr_sts;
  logic wr_ptr;
  sfb_op_t cmd_op;
  logic [2:0] cmd_bit;
  logic [31:0] cmd_word;
  logic [31:0] rdata_mux;

  // Address phase accepted on a live transfer
  assign take = hsel && hready && htrans[HTRANS_ACT_BIT];

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_q <= take && hwrite && (hsize == HSIZE_WORD);
      rd_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[ADDR_W-1:0];
      end
    end
  end

  // One wait state on reads so data sees prior writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
      hresp_r <= HRESP_OKAY;
    end else begin
      hreadyout_r <= !(take && !hwrite);
      hresp_r <= HRESP_OKAY;
      if (rd_q) begin
        hrdata_r <= rdata_mux;
      end
    end
  end

  // Write decode in the data phase
  assign busy = load_bus.busy;
  assign wr_cmd = wr_q && (addr_q == OFS_CMD);
  assign cmd_go = wr_cmd && !busy;
  assign sw_ok = wr_q && !busy;
  assign wr_wreg = sw_ok && (addr_q == OFS_WREG);
  assign wr_sts = sw_ok && (addr_q == OFS_STS);
  assign wr_ptr = sw_ok && (addr_q == OFS_PTR);
  assign cmd_op = sfb_op_t'(hwdata[CMD_OP_LSB +: CMD_OP_W]);
  assign cmd_bit = hwdata[CMD_BIT_LSB +: CMD_BIT_W];
  assign exec = cmd_go && !alu_bus.is_load;

  // Read data selection, unmapped reads as zero
  assign cmd_word = (32'(busy) << CMD_BUSY_BIT) | 32'(cmd_r);
  assign rdata_mux =
    (addr_q == OFS_CMD) ? cmd_word :
    (addr_q == OFS_WREG) ? 32'(wreg_r) :
    (addr_q == OFS_STS) ? 32'(sts_r) :
    (addr_q == OFS_PTR) ? 32'(ptr_r) : 32'h00000000;

  // Requests to the shift unit and load sequencer
  assign alu_bus.op = cmd_op;
  assign alu_bus.bit_idx = cmd_bit;
  assign alu_bus.wreg = wreg_r;
  assign alu_bus.sts = sts_r;
  assign load_bus.start = cmd_go && alu_bus.is_load;
  assign load_bus.op = cmd_op;
  assign load_bus.ptr = ptr_r;

  sfb_shift_unit u_shift (
    .alu(alu_bus.unit)
  );

  sfb_load_seq u_load (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(load_bus.seq)
  );

  // Next values, software writes blocked while a load runs
  assign wreg_nxt = wr_wreg ? hwdata[DATA_W-1:0] :
                    exec ? alu_bus.wreg_nxt : // RULE_01
                    load_bus.done ? mem_rdata : wreg_r; // RULE_11
  assign sts_nxt = wr_sts ? hwdata[DATA_W-1:0] :
                   exec ? alu_bus.sts_nxt : sts_r; // RULE_06
  assign ptr_nxt = wr_ptr ? hwdata[PTR_W-1:0] :
                   load_bus.ptr_we ? load_bus.ptr_new : ptr_r; // RULE_12

  // Datapath register update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wreg_r <= WREG_RST;
      sts_r <= STS_RST;
      ptr_r <= PTR_RST;
      cmd_r <= '0;
    end else begin
      wreg_r <= wreg_nxt;
      sts_r <= sts_nxt;
      ptr_r <= ptr_nxt;
      if (cmd_go) begin
        cmd_r <= {cmd_bit, cmd_op};
      end
    end
  end

  // Port drive
  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign mem_rd = load_bus.mem_rd;
  assign mem_addr = load_bus.mem_addr;

  // Helpers for bit-indexed checks
  logic wbit_q;
  logic [2:0] bit_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wbit_q <= 1'b0;
      bit_q <= '0;
    end else begin
      wbit_q <= wreg_r[cmd_bit];
      bit_q <= cmd_bit;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Shift and rotate checks
  a_shl_shift: assert property ( // RULE_01
    cmd_go && cmd_op == OP_SHL |=>
      wreg_r == {$past(wreg_r[MSB_BIT-1:0]), 1'b0})
    else $error("left shift result wrong");
  a_shl_flags: assert property ( // RULE_13
    cmd_go && cmd_op == OP_SHL |=>
      sts_r[FLG_C] == $past(wreg_r[MSB_BIT]) &&
      sts_r[FLG_Z] == (wreg_r == 8'h00))
    else $error("left shift carry or zero wrong");
  a_shr_shift: assert property ( // RULE_02
    cmd_go && cmd_op == OP_SHR |=>
      wreg_r == {1'b0, $past(wreg_r[MSB_BIT:1])} && !sts_r[FLG_N] &&
      sts_r[FLG_C] == $past(wreg_r[0]) &&
      sts_r[FLG_V] == sts_r[FLG_C])
    else $error("right shift result or flags wrong");
  a_rotl_carry: assert property ( // RULE_03
    cmd_go && cmd_op == OP_ROTL |=>
      wreg_r[0] == $past(sts_r[FLG_C]) &&
      sts_r[FLG_C] == $past(wreg_r[MSB_BIT]))
    else $error("rotate left carry path wrong");
  a_rotr_carry: assert property ( // RULE_04
    cmd_go && cmd_op == OP_ROTR |=>
      wreg_r[MSB_BIT] == $past(sts_r[FLG_C]) &&
      sts_r[FLG_C] == $past(wreg_r[0]))
    else $error("rotate right carry path wrong");
  a_sar_sign: assert property ( // RULE_05
    cmd_go && cmd_op == OP_SAR |=>
      wreg_r[MSB_BIT] == $past(wreg_r[MSB_BIT]) &&
      wreg_r[MSB_BIT-1:0] == $past(wreg_r[MSB_BIT:1]) &&
      sts_r[FLG_N] == wreg_r[MSB_BIT])
    else $error("arithmetic shift wrong");

  // Single-flag operations
  a_sflag_only: assert property ( // RULE_06
    cmd_go && (cmd_op == OP_S_SET || cmd_op == OP_S_CLR) |=>
      sts_r[FLG_S] == ($past(cmd_op) == OP_S_SET) &&
      ((sts_r ^ $past(sts_r)) & ~flag_mask(FLG_S)) == 8'h00 &&
      $stable(wreg_r))
    else $error("signed flag op touched other state");
  a_vflag_only: assert property ( // RULE_07
    cmd_go && (cmd_op == OP_V_SET || cmd_op == OP_V_CLR) |=>
      sts_r[FLG_V] == ($past(cmd_op) == OP_V_SET) &&
      ((sts_r ^ $past(sts_r)) & ~flag_mask(FLG_V)) == 8'h00)
    else $error("overflow flag op touched other flags");
  a_hflag_only: assert property ( // RULE_08
    cmd_go && (cmd_op == OP_H_SET || cmd_op == OP_H_CLR) |=>
      sts_r[FLG_H] == ($past(cmd_op) == OP_H_SET) &&
      ((sts_r ^ $past(sts_r)) & ~flag_mask(FLG_H)) == 8'h00)
    else $error("half-carry op touched other flags");

  // Bit transfer operations
  a_tflag_store: assert property ( // RULE_09
    cmd_go && cmd_op == OP_BIT_TO_T |=>
      sts_r[FLG_T] == wbit_q &&
      ((sts_r ^ $past(sts_r)) & ~flag_mask(FLG_T)) == 8'h00)
    else $error("bit store to transfer flag wrong");
  a_tbit_load: assert property ( // RULE_10
    cmd_go && cmd_op == OP_T_TO_BIT |=>
      wreg_r[bit_q] == $past(sts_r[FLG_T]) && $stable(sts_r))
    else $error("bit load from transfer flag wrong");

  // Indirect loads
  a_load_postinc: assert property ( // RULE_11
    cmd_go && cmd_op == OP_LOAD_POST |=>
      mem_rd && mem_addr == $past(ptr_r) && $stable(ptr_r) ##1
      !mem_rd && !busy && ptr_r == $past(ptr_r) + PTR_STEP &&
      wreg_r == $past(mem_rdata) && $stable(sts_r))
    else $error("post-increment load sequence wrong");
  a_load_predec: assert property ( // RULE_12
    cmd_go && cmd_op == OP_LOAD_PRE |=>
      mem_rd && ptr_r == $past(ptr_r) - PTR_STEP && mem_addr == ptr_r ##1
      !busy && $stable(ptr_r) && wreg_r == $past(mem_rdata))
    else $error("pre-decrement load sequence wrong");

  // Main scenarios
  c_rotate: cover property (cmd_go && cmd_op == OP_ROTL);
  c_predec: cover property (cmd_go && cmd_op == OP_LOAD_PRE ##2 rd_q);
  c_refused: cover property (wr_cmd && busy);
  c_tbit: cover property (cmd_go && cmd_op == OP_T_TO_BIT);

endmodule : sfb_top
`default_nettype wire

// ---- sim/sfb_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Data memory with an asynchronous read port
module sfb_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] last_r;
  logic [7:0] pat;
  // Contents follow the address; idle bus shows inverted last value
  assign pat = mem_addr[7:0] ^ {mem_addr[14:8], mem_addr[15]} ^ 8'h3C;
  assign mem_rdata = mem_rd ? pat : ~last_r;
  // Remember the last value driven for the idle pattern
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_r <= 8'h00;
    end else if (mem_rd) begin
      last_r <= pat;
    end
  end
endmodule : sfb_mem_model
`default_nettype wire

// ---- sim/tb_shift_flag_bit_load_datapath.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_shift_flag_bit_load_datapath;
  import sfb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mem_rd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] mem_addr, rd_addr;
  logic [7:0] mem_rdata;
  int mismatches, checked, rd_cnt;

  sfb_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  sfb_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  // Count memory strobes and keep the address read
  always @(posedge hclk) begin
    if (mem_rd === 1'b1) begin
      rd_cnt++;
      rd_addr = mem_addr;
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: bus hang", $time);
      tally_and_finish();
    end
  endtask : wait_rdy

  // One single AHB-Lite transfer, address then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [2:0] sz, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, HSIZE_WORD, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, HSIZE_WORD, q);
    check(q, e);
  endtask : rd_chk

  // Expected working register and flags after one operation
  function automatic logic [15:0] exp_alu(input logic [3:0] op,
      input logic [2:0] b, input logic [7:0] w, input logic [7:0] s);
    logic [7:0] r;
    logic [7:0] f;
    logic c;
    r = w;
    f = s;
    c = s[FLG_C];
    case (op)
      4'h0: begin r = {w[6:0], 1'b0}; c = w[7]; end
      4'h1: begin r = {1'b0, w[7:1]}; c = w[0]; end
      4'h2: begin r = {w[6:0], s[FLG_C]}; c = w[7]; end
      4'h3: begin r = {s[FLG_C], w[7:1]}; c = w[0]; end
      4'h4: begin r = {w[7], w[7:1]}; c = w[0]; end
      4'h5: f[FLG_S] = 1'b1;
      4'h6: f[FLG_S] = 1'b0;
      4'h7: f[FLG_V] = 1'b1;
      4'h8: f[FLG_V] = 1'b0;
      4'h9: f[FLG_H] = 1'b1;
      4'hA: f[FLG_H] = 1'b0;
      4'hB: f[FLG_T] = w[b];
      4'hC: r[b] = s[FLG_T];
      default: r = w;
    endcase
    if (op <= 4'h4) begin
      f[FLG_C] = c;
      f[FLG_Z] = (r == 8'h00);
      f[FLG_N] = r[7];
      f[FLG_V] = r[7] ^ c;
    end
    return {r, f};
  endfunction : exp_alu

  task automatic run_op(input logic [3:0] op, input logic [2:0] b,
      input logic [7:0] w, input logic [7:0] s);
    logic [15:0] e;
    e = exp_alu(op, b, w, s);
    wr(OFS_WREG, {24'h0, w});
    wr(OFS_STS, {24'h0, s});
    wr(OFS_CMD, {25'h0, b, op});
    rd_chk(OFS_WREG, {24'h0, e[15:8]});
    rd_chk(OFS_STS, {24'h0, e[7:0]});
    rd_chk(OFS_CMD, {25'h0, b, op});
  endtask : run_op

  task automatic run_load(input logic [3:0] op, input logic [15:0] p);
    logic [15:0] a;
    logic [15:0] np;
    logic [7:0] s;
    int n0;
    a = (op == OP_LOAD_PRE) ? p - 16'h1 : p;
    np = (op == OP_LOAD_POST) ? p + 16'h1 : a;
    s = 8'($urandom);
    wr(OFS_STS, {24'h0, s});
    wr(OFS_PTR, {16'h0, p});
    n0 = rd_cnt;
    wr(OFS_CMD, {28'h0, op});
    rd_chk(OFS_WREG, {24'h0, a[7:0] ^ {a[14:8], a[15]} ^ 8'h3C});
    rd_chk(OFS_PTR, {16'h0, np});
    rd_chk(OFS_STS, {24'h0, s});
    check(32'(rd_cnt - n0), 32'h1);
    check({16'h0, rd_addr}, {16'h0, a});
  endtask : run_load

  initial begin
    logic [31:0] q;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    rd_cnt = 0;
    void'($urandom(32'h5d01));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and an unmapped place
    rd_chk(OFS_CMD, 32'h0);
    rd_chk(OFS_WREG, {24'h0, WREG_RST});
    rd_chk(OFS_STS, {24'h0, STS_RST});
    rd_chk(OFS_PTR, {16'h0, PTR_RST});
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0);
    // Corner values of shifts and rotates
    run_op(OP_SHL, 3'h0, 8'h80, 8'h00);
    run_op(OP_SHL, 3'h0, 8'h7F, 8'hFF);
    run_op(OP_SHR, 3'h0, 8'h01, 8'hFF);
    run_op(OP_ROTL, 3'h0, 8'h80, 8'h01);
    run_op(OP_ROTR, 3'h0, 8'h01, 8'h01);
    run_op(OP_SAR, 3'h0, 8'h81, 8'h00);
    // Every single-cycle operation at random
    for (int i = 0; i < 150; i++) begin
      run_op(4'($urandom_range(12, 0)), 3'($urandom), 8'($urandom),
        8'($urandom));
    end
    // Indirect loads with pointer wrap at both ends
    for (int k = 0; k < 3; k++) begin
      run_load(4'(OP_LOAD_POST) + 4'(k), 16'hFFFF);
      run_load(4'(OP_LOAD_POST) + 4'(k), 16'h0000);
      repeat (4) run_load(4'(OP_LOAD_POST) + 4'(k), 16'($urandom));
    end
    // A byte-sized write is ignored
    wr(OFS_WREG, 32'h0000_003C);
    ahb(1'b1, OFS_WREG, 32'h0000_00FF, 3'h0, q);
    rd_chk(OFS_WREG, 32'h0000_003C);
    tally_and_finish();
  end
endmodule : tb_shift_flag_bit_load_datapath
`default_nettype wire
